// *** adcc_defines.svh ***
// Purpose: offsets, field positions, reset values and counts for adcc
// Assumes: 32-bit register words, one aligned word each
// Notes: included by bare name only
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define ADCC_OFF_CONTROL_0 6'h00
`define ADCC_OFF_CONTROL_1 6'h04
`define ADCC_OFF_PIN_ENABLE 6'h08
`define ADCC_OFF_RESULT_LOW 6'h0c
`define ADCC_OFF_RESULT_HIGH 6'h10
`define ADCC_OFF_IRQ 6'h14

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ADCC_C0_START 7
`define ADCC_C0_PENDING 6
`define ADCC_C0_POWER_DOWN 5
`define ADCC_C0_CH_LO_MSB 2
`define ADCC_C1_CH_HI 7
`define ADCC_C1_REF_SEL 3
`define ADCC_C1_DIV_MSB 2
`define ADCC_IRQ_FLAG 0
`define ADCC_IRQ_ENABLE 1
`define ADCC_IRQ_GLOBAL 2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ADCC_RST_POWER_DOWN 1'b1
`define ADCC_RST_PENDING 1'b1
`define ADCC_RST_PIN_ENABLE 8'hff
`define ADCC_RST_DIV 3'h0
`define ADCC_RST_CHANNEL 4'h0

// ----------------------------------------------------------------------
// timing counts in converter clock periods, then divider and bus response codes
// ----------------------------------------------------------------------
`define ADCC_SAMPLE_PERIODS 4'h4
`define ADCC_RESULT_BITS 4'hc
`define ADCC_DIV_UNDEFINED 3'h7
`define ADCC_RESP_OKAY 2'h0
`define ADCC_RESP_SLVERR 2'h2

`endif

// *** adcc_pkg.sv ***
// Purpose: shared types of the converter control block
// Assumes: constants live in adcc_defines.svh
// Notes: types only
`default_nettype none
package adcc_pkg;

    // converter sequencer states
    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_HOLD,
        ADCC_SAMPLE,
        ADCC_CONVERT
    } adcc_state_t;

    // requests from the port logic for the eight shared pins
    typedef struct packed {
        logic [7:0] pullup_request;
        logic [7:0] port_c_direction;
    } adcc_pin_req_t;

    // effective pin controls after analog override
    typedef struct packed {
        logic [7:0] analog_route;
        logic [7:0] digital_disable;
        logic [7:0] pullup_enable;
        logic [7:0] output_enable;
    } adcc_pin_ctl_t;

    // controls toward the analog macro
    typedef struct packed {
        logic power_on;
        logic reference_select;
        logic vref_pin_takeover;
        logic sample_hold;
        logic [3:0] channel_select;
        logic [11:0] trial_code;
    } adcc_analog_t;

endpackage : adcc_pkg
`default_nettype wire

// *** adcc_clkdiv.sv ***
// Purpose: converter clock tick generator, sys_clk divided by 2**code
// Assumes: code 111 is never selected by software
// Notes: restart aligns the first tick to a full period
`default_nettype none
`include "adcc_defines.svh"
module adcc_clkdiv (
    input wire logic sys_clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic ce, // clock enable
    input wire logic restart, // realign divider
    input wire logic [2:0] converter_clock_divider, // ratio code
    output logic tick // one converter clock period elapsed
);
    import adcc_pkg::*;

    logic [5:0] count;
    logic [5:0] limit;

    // terminal count per code, undefined code gives no ticks
    always_comb begin
        limit = 6'(7'h01 << converter_clock_divider) - 6'h01;
    end

    // free counter, cleared at terminal count or restart
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count <= 6'h00;
        end else if (ce) begin
            if (restart || count == limit) begin
                count <= 6'h00;
            end else begin
                count <= count + 6'h01;
            end
        end
    end

    // tick once per converter clock period
    assign tick = ce && !restart && (count == limit) &&
        (converter_clock_divider != `ADCC_DIV_UNDEFINED);

endmodule : adcc_clkdiv
`default_nettype wire

// *** adcc_top.sv ***
// Purpose: successive-approximation converter control with AXI4-Lite
// Assumes: comparator_high comes from the analog macro on sys_clk
// Notes: analog macro does conversion analog work; this is its sequencer
//
// Functional notes
// - power down bit shuts analog off
// - reference select picks supply or pin
// - analog select routes pin, disables digital
// - analog pin drops its pull-up
// - analog select overrides port direction
// - channel field split across both controls
// - start high then low begins conversion
// - pending clears at end, result valid
// - conversion lasts sixteen converter clocks
// - four sample periods, one per bit
// - converter clock sys divided by powers
// - twelve-bit unsigned code, full scale fff
// - half-step offset applied in analog
// - divider codes 000 to 110 only
// - start held high resets, pending high
// - completion sets converter interrupt flag
`default_nettype none
`include "adcc_defines.svh"
module adcc_top (
    input wire logic sys_clk, // 200 MHz system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic ce, // clock enable, freezes state when low
    input wire logic [5:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [5:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic comparator_high, // input above trial level
    input wire adcc_pkg::adcc_pin_req_t pin_req, // port logic requests
    output adcc_pkg::adcc_pin_ctl_t pin_ctl, // effective pin controls
    output adcc_pkg::adcc_analog_t analog, // analog macro controls
    output logic irq_request // end-of-conversion interrupt request
);
    import adcc_pkg::*;

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic start_bit;
    logic conversion_pending_flag;
    logic converter_power_down;
    logic [2:0] channel_low;
    logic channel_high;
    logic reference_select;
    logic [2:0] converter_clock_divider;
    logic [7:0] pin_analog_select;
    logic converter_irq_flag;
    logic converter_irq_enable;
    logic global_irq_enable;
    logic [11:0] result;

    // sequencer state
    adcc_state_t state;
    logic [3:0] period_count;
    logic [3:0] bit_index;
    logic [11:0] trial_code;
    logic tick;
    logic restart_div;
    logic done;

    // bus state
    logic aw_held;
    logic w_held;
    logic [5:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic wr_hit;
    logic [31:0] next_rdata;
    logic rd_hit;
    logic irq_clear;

    // ------------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------------
    // address and data are taken independently, response after both
    assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
    assign s_axi_wready = ce && !w_held && !s_axi_bvalid;
    assign wr_fire = ce && aw_held && w_held && !s_axi_bvalid;

    // capture write address
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aw_held <= 1'b0;
            aw_addr <= 6'h00;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
        end
    end

    // capture write data
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // write address decode
    always_comb begin
        case ({aw_addr[5:2], 2'b00})
            `ADCC_OFF_CONTROL_0, `ADCC_OFF_CONTROL_1,
            `ADCC_OFF_PIN_ENABLE, `ADCC_OFF_RESULT_LOW,
            `ADCC_OFF_RESULT_HIGH, `ADCC_OFF_IRQ: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // write response
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADCC_RESP_OKAY;
        end else if (ce) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // control registers, byte lane 0 only
    // ------------------------------------------------------------------
    // control 0: start, power down, low channel bits
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            start_bit <= 1'b0;
            converter_power_down <= `ADCC_RST_POWER_DOWN;
            channel_low <= 3'(`ADCC_RST_CHANNEL);
        end else if (ce && wr_fire && w_strb[0] &&
                     {aw_addr[5:2], 2'b00} == `ADCC_OFF_CONTROL_0) begin
            start_bit <= w_data[`ADCC_C0_START];
            converter_power_down <= w_data[`ADCC_C0_POWER_DOWN];
            channel_low <= w_data[`ADCC_C0_CH_LO_MSB:0];
        end
    end

    // control 1: high channel bit, reference, divider
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            channel_high <= 1'b0;
            reference_select <= 1'b0;
            converter_clock_divider <= `ADCC_RST_DIV;
        end else if (ce && wr_fire && w_strb[0] &&
                     {aw_addr[5:2], 2'b00} == `ADCC_OFF_CONTROL_1) begin
            channel_high <= w_data[`ADCC_C1_CH_HI];
            reference_select <= w_data[`ADCC_C1_REF_SEL];
            converter_clock_divider <= w_data[`ADCC_C1_DIV_MSB:0];
        end
    end

    // analog pin select and interrupt enables
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_analog_select <= `ADCC_RST_PIN_ENABLE;
            converter_irq_enable <= 1'b0;
            global_irq_enable <= 1'b0;
        end else if (ce && wr_fire && w_strb[0]) begin
            if ({aw_addr[5:2], 2'b00} == `ADCC_OFF_PIN_ENABLE) begin
                pin_analog_select <= w_data[7:0];
            end
            if ({aw_addr[5:2], 2'b00} == `ADCC_OFF_IRQ) begin
                converter_irq_enable <= w_data[`ADCC_IRQ_ENABLE];
                global_irq_enable <= w_data[`ADCC_IRQ_GLOBAL];
            end
        end
    end

    // writing one to the flag bit clears it
    assign irq_clear = wr_fire && w_strb[0] && w_data[`ADCC_IRQ_FLAG] &&
        {aw_addr[5:2], 2'b00} == `ADCC_OFF_IRQ;

    // sticky flag, completion wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            converter_irq_flag <= 1'b0;
        end else if (ce) begin
            converter_irq_flag <= done ||
                (converter_irq_flag && !irq_clear);
        end
    end

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    assign s_axi_arready = ce && !s_axi_rvalid;

    // read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        rd_hit = 1'b1;
        case ({s_axi_araddr[5:2], 2'b00})
            `ADCC_OFF_CONTROL_0: begin
                next_rdata[`ADCC_C0_START] = start_bit;
                next_rdata[`ADCC_C0_PENDING] = conversion_pending_flag;
                next_rdata[`ADCC_C0_POWER_DOWN] = converter_power_down;
                next_rdata[`ADCC_C0_CH_LO_MSB:0] = channel_low;
            end
            `ADCC_OFF_CONTROL_1: begin
                next_rdata[`ADCC_C1_CH_HI] = channel_high;
                next_rdata[`ADCC_C1_REF_SEL] = reference_select;
                next_rdata[`ADCC_C1_DIV_MSB:0] = converter_clock_divider;
            end
            `ADCC_OFF_PIN_ENABLE: next_rdata[7:0] = pin_analog_select;
            `ADCC_OFF_RESULT_LOW: next_rdata[7:0] = result[7:0];
            `ADCC_OFF_RESULT_HIGH: next_rdata[3:0] = result[11:8];
            `ADCC_OFF_IRQ: begin
                next_rdata[`ADCC_IRQ_FLAG] = converter_irq_flag;
                next_rdata[`ADCC_IRQ_ENABLE] = converter_irq_enable;
                next_rdata[`ADCC_IRQ_GLOBAL] = global_irq_enable;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // registered read answer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ADCC_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= rd_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // converter sequencer
    // ------------------------------------------------------------------
    adcc_clkdiv u_clkdiv (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .restart(restart_div),
        .converter_clock_divider(converter_clock_divider),
        .tick(tick)
    );

    // divider realigns while idle or held
    assign restart_div = (state == ADCC_IDLE) || (state == ADCC_HOLD);
    assign done = ce && tick && state == ADCC_CONVERT &&
        bit_index == 4'h0;

    // start rise resets, start fall launches, power down aborts
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= ADCC_IDLE;
            period_count <= 4'h0;
            bit_index <= 4'h0;
            trial_code <= 12'h000;
        end else if (ce) begin
            if (converter_power_down) begin
                state <= ADCC_IDLE;
            end else if (start_bit) begin
                state <= ADCC_HOLD;
            end else begin
                case (state)
                    ADCC_HOLD: begin
                        state <= ADCC_SAMPLE;
                        period_count <= 4'h0;
                        trial_code <= 12'h000;
                    end
                    ADCC_SAMPLE: if (tick) begin
                        if (period_count == `ADCC_SAMPLE_PERIODS - 4'h1)
                        begin
                            state <= ADCC_CONVERT;
                            bit_index <= `ADCC_RESULT_BITS - 4'h1;
                            trial_code <= 12'h800;
                        end else begin
                            period_count <= period_count + 4'h1;
                        end
                    end
                    ADCC_CONVERT: if (tick) begin
                        // keep the trial bit only if input is above it
                        trial_code[bit_index] <= comparator_high;
                        if (bit_index == 4'h0) begin
                            state <= ADCC_IDLE;
                        end else begin
                            trial_code[bit_index - 4'h1] <= 1'b1;
                            bit_index <= bit_index - 4'h1;
                        end
                    end
                    ADCC_IDLE: state <= ADCC_IDLE;
                    default: state <= ADCC_IDLE;
                endcase
            end
        end
    end

    // result only changes at completion
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result <= 12'h000;
        end else if (done) begin
            result <= {trial_code[11:1], comparator_high};
        end
    end

    // pending flag: forced high by start, cleared at completion
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            conversion_pending_flag <= `ADCC_RST_PENDING;
        end else if (ce) begin
            if (start_bit) begin
                conversion_pending_flag <= 1'b1;
            end else if (done && !converter_power_down) begin
                conversion_pending_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // pin and analog outputs
    // ------------------------------------------------------------------
    // analog select takes the pin from the digital port
    assign pin_ctl.analog_route = pin_analog_select;
    assign pin_ctl.digital_disable = pin_analog_select;
    assign pin_ctl.pullup_enable =
        pin_req.pullup_request & ~pin_analog_select;
    assign pin_ctl.output_enable =
        pin_req.port_c_direction & ~pin_analog_select;

    // analog macro controls
    assign analog.power_on = !converter_power_down;
    assign analog.reference_select = reference_select;
    assign analog.vref_pin_takeover = reference_select;
    assign analog.sample_hold = (state == ADCC_SAMPLE);
    assign analog.channel_select = {channel_high, channel_low};
    // the macro applies the half-step offset to the trial level
    assign analog.trial_code = trial_code;

    // interrupt request needs both enables
    assign irq_request = converter_irq_flag && converter_irq_enable &&
        global_irq_enable;

endmodule : adcc_top
`default_nettype wire

// *** adcc_top_sva.sv ***
// Purpose: port-level checks of the converter control block
// Assumes: one clock domain, reset synchronous and active high
// Notes: bound into adcc_top
`default_nettype none
module adcc_top_sva import adcc_pkg::*; (
    input wire logic sys_clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic [1:0] s_axi_bresp, // write response
    input wire logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic s_axi_arready, // read address ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire adcc_pin_req_t pin_req, // pin requests
    input wire adcc_pin_ctl_t pin_ctl, // pin controls
    input wire adcc_analog_t analog // analog controls
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // pin override relations
    a_pull_drop: assert property (pin_ctl.pullup_enable ==
        (pin_req.pullup_request & ~pin_ctl.analog_route))
        else $error("pullup kept");
    a_dir_override: assert property (pin_ctl.output_enable ==
        (pin_req.port_c_direction & ~pin_ctl.analog_route))
        else $error("direction kept");
    a_digital_off: assert property (pin_ctl.digital_disable ==
        pin_ctl.analog_route)
        else $error("digital kept");
    a_vref_take: assert property (analog.vref_pin_takeover ==
        analog.reference_select)
        else $error("vref pin kept");
    // converter sequencing
    a_power_idle: assert property (!analog.power_on |->
        !analog.sample_hold)
        else $error("sample when off");
    a_sample_len: assert property ($rose(analog.sample_hold) |->
        analog.sample_hold[*4] ##[1:260] !analog.sample_hold)
        else $error("sample length");
    // bus answers stand until taken
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
    a_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata dropped");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("ar taken busy");
endmodule : adcc_top_sva

bind adcc_top adcc_top_sva u_sva (.*);
`default_nettype wire

// *** adcc_analog_model.sv ***
// Purpose: ideal comparator standing in for the analog input side
// Assumes: input level given as its ideal code
// Notes: combinational, same-cycle answer
`default_nettype none
module adcc_analog_model import adcc_pkg::*; (
    input wire adcc_analog_t analog, // converter controls
    input wire logic [11:0] vin, // input level as ideal code
    output logic comparator_high // input at or above trial
);
    timeunit 1ns;
    timeprecision 1ps;
    // unpowered comparator gives no steady answer
    assign comparator_high = analog.power_on ?
        (vin >= analog.trial_code) : ~analog.trial_code[0];
endmodule : adcc_analog_model
`default_nettype wire

// *** adc_conversion_control_tb.sv ***
// Purpose: self-checking bench for adcc_top
// Assumes: AXI4-Lite master, ideal comparator model on the far side
// Notes: monitor compares answers with queued notes
`default_nettype none
`include "adcc_defines.svh"
module adc_conversion_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adcc_pkg::*;
    logic sys_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, comparator_high, irq_request;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    adcc_pin_req_t pin_req;
    adcc_pin_ctl_t pin_ctl;
    adcc_analog_t analog;
    logic [11:0] vin, prev;
    logic [7:0] sel;
    logic [33:0] exp_r[$];
    logic [1:0] exp_b[$];
    logic [31:0] lf = 32'hb083;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int n;

    adcc_top dut (.sys_clk, .rst, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comparator_high,
        .pin_req, .pin_ctl, .analog, .irq_request);
    adcc_analog_model far (.analog, .vin, .comparator_high);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt

    function automatic logic [33:0] ok(input logic [7:0] v);
        return {26'h0, v};
    endfunction : ok

    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task close_out;
        $display("checks %0d fails %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    // bus write, AW and W together
    task wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] r);
        exp_b.push_back(r);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {lf[31:8], d};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        do @(posedge sys_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr

    // bus read, note for the monitor
    task rd(input logic [5:0] a, input logic [33:0] e);
        exp_r.push_back(e);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd

    // monitor against the oldest notes
    always @(posedge sys_clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            chk({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
        end
        if (s_axi_bvalid && s_axi_bready) begin
            chk({32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
        end
    end

    // clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 48'h0;
        pin_req = '0;
        vin = 12'h0;
        prev = 12'h0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`ADCC_OFF_CONTROL_0, ok(8'h60));
        rd(`ADCC_OFF_CONTROL_1, ok(8'h00));
        rd(`ADCC_OFF_PIN_ENABLE, ok(8'hff));
        rd(`ADCC_OFF_RESULT_HIGH, ok(8'h00));
        rd(6'h18, {`ADCC_RESP_SLVERR, 32'h0});
        wr(6'h1c, 8'h55, `ADCC_RESP_SLVERR);
        for (int i = 0; i < 3; i++) begin
            lf = nxt(lf);
            sel = lf[7:0];
            wr(`ADCC_OFF_PIN_ENABLE, sel, `ADCC_RESP_OKAY);
            pin_req <= lf[23:8];
            @(posedge sys_clk);
            chk({2'h0, pin_ctl}, {2'h0, sel, sel,
                lf[23:16] & ~sel, lf[15:8] & ~sel});
        end
        wr(`ADCC_OFF_CONTROL_1, 8'h88, `ADCC_RESP_OKAY);
        wr(`ADCC_OFF_CONTROL_0, 8'h05, `ADCC_RESP_OKAY);
        @(posedge sys_clk);
        chk({27'h0, analog.power_on, analog.reference_select,
            analog.vref_pin_takeover, analog.channel_select}, 34'h7d);
        wr(`ADCC_OFF_IRQ, 8'h06, `ADCC_RESP_OKAY);
        // one conversion per divider code
        for (int c = 0; c < 7; c++) begin
            lf = nxt(lf);
            vin <= lf[11:0];
            wr(`ADCC_OFF_CONTROL_1, 8'h88 | 8'(c), `ADCC_RESP_OKAY);
            wr(`ADCC_OFF_CONTROL_0, 8'h85, `ADCC_RESP_OKAY);
            rd(`ADCC_OFF_CONTROL_0, ok(8'hc5));
            rd(`ADCC_OFF_RESULT_LOW, ok(prev[7:0]));
            wr(`ADCC_OFF_CONTROL_0, 8'h05, `ADCC_RESP_OKAY);
            n = 0;
            while (!irq_request && n < 3000) begin
                @(posedge sys_clk);
                n++;
            end
            chk({33'h0, n >= (16 << c) - 3 && n <= (16 << c) + 3}, 34'h1);
            rd(`ADCC_OFF_RESULT_LOW, ok(vin[7:0]));
            rd(`ADCC_OFF_RESULT_HIGH, ok({4'h0, vin[11:8]}));
            rd(`ADCC_OFF_CONTROL_0, ok(8'h05));
            rd(`ADCC_OFF_IRQ, ok(8'h07));
            wr(`ADCC_OFF_IRQ, 8'h02, `ADCC_RESP_OKAY);
            @(posedge sys_clk);
            chk({33'h0, irq_request}, 34'h0);
            wr(`ADCC_OFF_IRQ, 8'h07, `ADCC_RESP_OKAY);
            rd(`ADCC_OFF_IRQ, ok(8'h06));
            prev = vin;
        end
        wr(`ADCC_OFF_CONTROL_0, 8'h20, `ADCC_RESP_OKAY);
        @(posedge sys_clk);
        chk({33'h0, analog.power_on}, 34'h0);
        rd(`ADCC_OFF_CONTROL_0, ok(8'h20));
        repeat (4) @(posedge sys_clk);
        close_out();
    end
endmodule : adc_conversion_control_tb
`default_nettype wire
